// ===== ebac_regs.vh
// Register map, reset values and field positions of the external bus area configuration block.
// Assumes inclusion by the design files by bare name; holds definitions only.
`ifndef EBAC_REGS_VH
`define EBAC_REGS_VH

// Register indices; the AXI4-Lite byte address is four times the index.
`define EBAC_IDX_AREA_BUS_WIDTH 16'hFFEC
`define EBAC_IDX_AREA_ACCESS_STATES 16'hFFED
`define EBAC_IDX_WAIT_CONTROL 16'hFFEE
`define EBAC_IDX_WAIT_CONTROL_ENABLE 16'hFFEF
`define EBAC_IDX_BUS_RELEASE_CONTROL 16'hFFF3
`define EBAC_ADDR_W 18
`define EBAC_ADDR_AREA_BUS_WIDTH 18'h3FFB0
`define EBAC_ADDR_AREA_ACCESS_STATES 18'h3FFB4
`define EBAC_ADDR_WAIT_CONTROL 18'h3FFB8
`define EBAC_ADDR_WAIT_CONTROL_ENABLE 18'h3FFBC
`define EBAC_ADDR_BUS_RELEASE_CONTROL 18'h3FFCC
`define EBAC_ADDR_BUS_STATUS 18'h3FFD0

// Reset values.
`define EBAC_RST_WIDTH_NARROW 8'hFF
`define EBAC_RST_WIDTH_WIDE 8'h00
`define EBAC_RST_ACCESS_STATES 8'hFF
`define EBAC_RST_WAIT_CONTROL 8'hF3
`define EBAC_RST_WAIT_ENABLE 8'hFF
`define EBAC_RST_BUS_RELEASE 8'hFE

// Read-only-one masks and writable masks.
`define EBAC_WAIT_CONTROL_RO_MASK 8'hF0
`define EBAC_BUS_RELEASE_RO_MASK 8'h1E
`define EBAC_BUS_RELEASE_ADDR_MASK 8'hE0
`define EBAC_BUS_RELEASE_EN_MASK 8'h01

// Field positions.
`define EBAC_WMS_HI 3
`define EBAC_WMS_LO 2
`define EBAC_WC_HI 1
`define EBAC_WC_LO 0
`define EBAC_A23_EN_BIT 7
`define EBAC_A22_EN_BIT 6
`define EBAC_A21_EN_BIT 5
`define EBAC_REL_EN_BIT 0

// Wait mode encodings.
`define EBAC_WMODE_PROG 2'h0
`define EBAC_WMODE_NONE 2'h1
`define EBAC_WMODE_PIN1 2'h2
`define EBAC_WMODE_AUTO 2'h3

// AXI response codes.
`define EBAC_RESP_OKAY 2'h0
`define EBAC_RESP_SLVERR 2'h2

`endif

// ===== ebac_area_cfg.v
// Per-area decode of width, access states and wait control for one selected area.
// Assumes the area index and on-chip flag come from the surrounding address decoder.
`timescale 1ns/10ps
`include "ebac_regs.vh"

module ebac_area_cfg #(
    parameter AREAS = 8
) (
    input wire [AREAS-1:0] width_bits,
    input wire [AREAS-1:0] state_bits,
    input wire [AREAS-1:0] wait_en_bits,
    input wire [2:0] area_sel,
    input wire onchip,
    output wire area_is_8bit,
    output wire area_is_3state,
    output wire area_wait_ctl,
    output wire area_pin_wait0
);
    // On-chip targets keep their fixed width and state count.
    assign area_is_8bit = ~onchip & width_bits[area_sel]; // [RULE1] [RULE5]
    assign area_is_3state = ~onchip & state_bits[area_sel]; // [RULE6] [RULE7]
    // Wait control only matters for external three-state areas.
    assign area_wait_ctl = area_is_3state & wait_en_bits[area_sel]; // [RULE11]
    assign area_pin_wait0 = area_is_3state & ~wait_en_bits[area_sel]; // [RULE11]
endmodule // ebac_area_cfg

// ===== ebac_pin_mux.v
// Pin function selection derived from the configuration registers.
// Assumes the operating mode is stable while in use.
`timescale 1ns/10ps
`include "ebac_regs.vh"

module ebac_pin_mux (
    input wire [7:0] width_reg,
    input wire [7:0] release_reg,
    input wire [2:0] op_mode,
    output wire bus_8bit_mode,
    output wire port4_gpio,
    output wire [2:0] addr_hi_out_en,
    output wire release_allowed
);
    wire mode_16m;
    assign mode_16m = (op_mode == 3'h3) || (op_mode == 3'h4);
    assign bus_8bit_mode = &width_reg; // [RULE2] [RULE3]
    assign port4_gpio = &width_reg; // [RULE2]
    // Upper address outputs exist only in the two large-space modes.
    assign addr_hi_out_en[2] = mode_16m & ~release_reg[`EBAC_A23_EN_BIT]; // [RULE13] [RULE14]
    assign addr_hi_out_en[1] = mode_16m & ~release_reg[`EBAC_A22_EN_BIT]; // [RULE13] [RULE14]
    assign addr_hi_out_en[0] = mode_16m & ~release_reg[`EBAC_A21_EN_BIT]; // [RULE13] [RULE14]
    assign release_allowed = release_reg[`EBAC_REL_EN_BIT]; // [RULE15]
endmodule // ebac_pin_mux

// ===== ebac_top.v
// Configuration register bank of the external bus controller, reached over AXI4-Lite.
// Assumes a single clock, synchronous active-low reset and a stable operating mode input.
//
// Contract
// [RULE1] Width bit zero sixteen-bit, one eight-bit
// [RULE2] All ones gives eight-bit bus mode
// [RULE3] Any zero gives sixteen-bit bus mode
// [RULE4] Width reset value depends on mode
// [RULE5] Width settings affect external areas only
// [RULE6] State bit zero two-state, one three-state
// [RULE7] On-chip accesses ignore state bits
// [RULE8] Wait control resets F3, upper bits one
// [RULE9] Wait mode select chooses four modes
// [RULE10] Wait count inserts zero to three
// [RULE11] Wait enable zero means pin wait
// [RULE12] Release control resets FE, bits 4-1 one
// [RULE13] Address enable zero drives upper address
// [RULE14] Address enables locked outside modes three, four
// [RULE15] Release enable bit permits bus release
// [RULE16] Registers hold through software standby
// [RULE17] External master requests, device acknowledges
// [RULE18] External wait request for three-state areas
// [RULE19] Reserved read-only bits ignore writes
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "ebac_regs.vh"

module ebac_top #(
    parameter AREAS = 8
) (
    aclk,
    aresetn,
    hw_standby,
    sw_standby,
    op_mode,
    area_sel,
    onchip,
    s_axi_awaddr,
    s_axi_awvalid,
    s_axi_awready,
    s_axi_wdata,
    s_axi_wstrb,
    s_axi_wvalid,
    s_axi_wready,
    s_axi_bresp,
    s_axi_bvalid,
    s_axi_bready,
    s_axi_araddr,
    s_axi_arvalid,
    s_axi_arready,
    s_axi_rdata,
    s_axi_rresp,
    s_axi_rvalid,
    s_axi_rready,
    bus_8bit_mode,
    port4_gpio,
    addr_hi_out_en,
    release_allowed,
    area_is_8bit,
    area_is_3state,
    area_wait_ctl,
    area_pin_wait0,
    wait_mode,
    wait_states
);
    input wire aclk;
    input wire aresetn;
    input wire hw_standby;
    input wire sw_standby;
    input wire [2:0] op_mode;
    input wire [2:0] area_sel;
    input wire onchip;
    input wire [`EBAC_ADDR_W-1:0] s_axi_awaddr;
    input wire s_axi_awvalid;
    output reg s_axi_awready;
    input wire [31:0] s_axi_wdata;
    input wire [3:0] s_axi_wstrb;
    input wire s_axi_wvalid;
    output reg s_axi_wready;
    output reg [1:0] s_axi_bresp;
    output reg s_axi_bvalid;
    input wire s_axi_bready;
    input wire [`EBAC_ADDR_W-1:0] s_axi_araddr;
    input wire s_axi_arvalid;
    output reg s_axi_arready;
    output reg [31:0] s_axi_rdata;
    output reg [1:0] s_axi_rresp;
    output reg s_axi_rvalid;
    input wire s_axi_rready;
    output reg bus_8bit_mode;
    output reg port4_gpio;
    output reg [2:0] addr_hi_out_en;
    output reg release_allowed;
    output reg area_is_8bit;
    output reg area_is_3state;
    output reg area_wait_ctl;
    output reg area_pin_wait0;
    output reg [1:0] wait_mode;
    output reg [1:0] wait_states;

    // ************************************************************
    // Configuration registers
    // ************************************************************
    reg [7:0] area_bus_width_reg; // Width bit per area.
    reg [7:0] area_access_states_reg; // State count bit per area.
    reg [3:0] wait_control_reg; // Only the writable low nibble is stored.
    reg [7:0] wait_control_enable_reg; // Wait control enable per area.
    reg [3:0] bus_release_control_reg; // Bits 7..5 and bit 0 packed.
    wire [7:0] wait_control_view; // Full byte as software sees it.
    wire [7:0] bus_release_view; // Full byte as software sees it.
    wire mode_narrow; // Modes whose width register resets to all ones.
    wire mode_16m; // Modes in which upper address enables are writable.
    wire init_regs; // Reset or hardware standby.

    assign mode_narrow = (op_mode == 3'h1) || (op_mode == 3'h3) ||
        (op_mode == 3'h5);
    assign mode_16m = (op_mode == 3'h3) || (op_mode == 3'h4);
    assign init_regs = ~aresetn | hw_standby;
    // Reserved bits are constant ones, so no write can reach them.
    assign wait_control_view = `EBAC_WAIT_CONTROL_RO_MASK |
        {4'h0, wait_control_reg}; // [RULE8] [RULE19]
    assign bus_release_view = {bus_release_control_reg[3:1], 4'hF,
        bus_release_control_reg[0]}; // [RULE12] [RULE19]

    // ************************************************************
    // AXI4-Lite write channel
    // ************************************************************
    reg aw_held; // Write address captured, awaiting data.
    reg w_held; // Write data captured, awaiting address.
    reg [`EBAC_ADDR_W-1:0] aw_addr_reg; // Captured write address.
    reg [31:0] w_data_reg; // Captured write data.
    reg w_strb0_reg; // Captured strobe of the low byte lane.
    wire aw_take; // Address handshake this edge.
    wire w_take; // Data handshake this edge.
    wire [`EBAC_ADDR_W-1:0] wr_addr; // Address of the write being committed.
    wire [7:0] wr_byte; // Low byte of the write being committed.
    wire wr_lane0; // Low byte lane enabled.
    wire wr_fire; // Both halves present, commit this edge.
    wire wr_hit; // Address maps to a register.

    assign aw_take = s_axi_awvalid & s_axi_awready;
    assign w_take = s_axi_wvalid & s_axi_wready;
    assign wr_addr = aw_held ? aw_addr_reg : s_axi_awaddr;
    assign wr_byte = w_held ? w_data_reg[7:0] : s_axi_wdata[7:0];
    assign wr_lane0 = w_held ? w_strb0_reg : s_axi_wstrb[0];
    assign wr_fire = (aw_held | aw_take) & (w_held | w_take);
    assign wr_hit = (wr_addr == `EBAC_ADDR_AREA_BUS_WIDTH) ||
        (wr_addr == `EBAC_ADDR_AREA_ACCESS_STATES) ||
        (wr_addr == `EBAC_ADDR_WAIT_CONTROL) ||
        (wr_addr == `EBAC_ADDR_WAIT_CONTROL_ENABLE) ||
        (wr_addr == `EBAC_ADDR_BUS_RELEASE_CONTROL) ||
        (wr_addr == `EBAC_ADDR_BUS_STATUS);

    // Handshake tracker: each half is accepted once, then held until the other half arrives.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr_reg <= {`EBAC_ADDR_W{1'b0}};
            w_data_reg <= 32'h00000000;
            w_strb0_reg <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `EBAC_RESP_OKAY;
        end else begin
            if (wr_fire) begin
                // Commit: release both holds and raise the response.
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_awready <= 1'b0;
                s_axi_wready <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `EBAC_RESP_OKAY : `EBAC_RESP_SLVERR;
            end else begin
                if (aw_take) begin
                    aw_held <= 1'b1;
                    aw_addr_reg <= s_axi_awaddr;
                end
                if (w_take) begin
                    w_held <= 1'b1;
                    w_data_reg <= s_axi_wdata;
                    w_strb0_reg <= s_axi_wstrb[0];
                end
                // Ready only while no response is pending and that half is still open.
                s_axi_awready <= ~s_axi_bvalid & ~aw_held & ~aw_take;
                s_axi_wready <= ~s_axi_bvalid & ~w_held & ~w_take;
                if (s_axi_bvalid && s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                end
            end
        end
    end

    // Register update. Software standby has no effect: only reset or hardware standby reloads.
    always @(posedge aclk) begin
        if (init_regs) begin
            area_bus_width_reg <= mode_narrow ? `EBAC_RST_WIDTH_NARROW :
                `EBAC_RST_WIDTH_WIDE; // [RULE4]
            area_access_states_reg <= `EBAC_RST_ACCESS_STATES; // [RULE6]
            wait_control_reg <= 4'h3; // [RULE8] [RULE9] [RULE10]
            wait_control_enable_reg <= `EBAC_RST_WAIT_ENABLE; // [RULE11]
            bus_release_control_reg <= 4'hE; // [RULE12]
        end else if (wr_fire && wr_lane0) begin
            // A write updates only the addressed register; all others hold. [RULE16]
            case (wr_addr)
                `EBAC_ADDR_AREA_BUS_WIDTH: begin
                    area_bus_width_reg <= wr_byte; // [RULE1]
                end
                `EBAC_ADDR_AREA_ACCESS_STATES: begin
                    area_access_states_reg <= wr_byte; // [RULE6]
                end
                `EBAC_ADDR_WAIT_CONTROL: begin
                    // The upper nibble is not stored.
                    wait_control_reg <= wr_byte[3:0]; // [RULE19]
                end
                `EBAC_ADDR_WAIT_CONTROL_ENABLE: begin
                    wait_control_enable_reg <= wr_byte; // [RULE11]
                end
                `EBAC_ADDR_BUS_RELEASE_CONTROL: begin
                    // Upper address enables are frozen outside the large-space modes.
                    if (mode_16m) begin
                        bus_release_control_reg[3:1] <= wr_byte[7:5]; // [RULE13]
                    end
                    bus_release_control_reg[0] <= wr_byte[`EBAC_REL_EN_BIT]; // [RULE15] [RULE14]
                end
                default: begin
                end
            endcase
        end
    end

    // ************************************************************
    // AXI4-Lite read channel
    // ************************************************************
    reg [7:0] rd_byte; // Register byte selected by the read address.
    reg rd_hit; // Read address maps to a register.

    // Read decode; the status word shows the derived bus state.
    always @* begin
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `EBAC_ADDR_AREA_BUS_WIDTH: rd_byte = area_bus_width_reg;
            `EBAC_ADDR_AREA_ACCESS_STATES: rd_byte = area_access_states_reg;
            `EBAC_ADDR_WAIT_CONTROL: rd_byte = wait_control_view;
            `EBAC_ADDR_WAIT_CONTROL_ENABLE: rd_byte = wait_control_enable_reg;
            `EBAC_ADDR_BUS_RELEASE_CONTROL: rd_byte = bus_release_view;
            `EBAC_ADDR_BUS_STATUS: rd_byte = {2'h0, sw_standby, mode_16m,
                release_allowed, port4_gpio,
                bus_8bit_mode, ~bus_8bit_mode}; // [RULE2] [RULE3]
            default: begin
                rd_byte = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    // One read at a time: ready for one cycle, data on the following edge, held until taken.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `EBAC_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, rd_byte};
                s_axi_rresp <= rd_hit ? `EBAC_RESP_OKAY : `EBAC_RESP_SLVERR;
            end else begin
                if (s_axi_rvalid && s_axi_rready) begin
                    s_axi_rvalid <= 1'b0;
                end
                s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
            end
        end
    end

    // ************************************************************
    // Derived controls toward the bus state machine and pins
    // ************************************************************
    wire bus_8bit_mode_c; // Eight-bit bus mode.
    wire port4_gpio_c; // Port 4 free for general use.
    wire [2:0] addr_hi_out_en_c; // Upper address pin enables, bit 2 is line 23.
    wire release_allowed_c; // Bus may be granted to an external master.
    wire area_is_8bit_c; // Selected area is eight bits wide.
    wire area_is_3state_c; // Selected area uses three states.
    wire area_wait_ctl_c; // Wait unit controls the selected area.
    wire area_pin_wait0_c; // Selected area falls back to pin wait mode 0.

    ebac_pin_mux u_pin_mux (
        .width_reg(area_bus_width_reg),
        .release_reg(bus_release_view),
        .op_mode(op_mode),
        .bus_8bit_mode(bus_8bit_mode_c),
        .port4_gpio(port4_gpio_c),
        .addr_hi_out_en(addr_hi_out_en_c),
        .release_allowed(release_allowed_c)
    );

    ebac_area_cfg #(
        .AREAS(AREAS)
    ) u_area_cfg (
        .width_bits(area_bus_width_reg),
        .state_bits(area_access_states_reg),
        .wait_en_bits(wait_control_enable_reg),
        .area_sel(area_sel),
        .onchip(onchip),
        .area_is_8bit(area_is_8bit_c),
        .area_is_3state(area_is_3state_c),
        .area_wait_ctl(area_wait_ctl_c),
        .area_pin_wait0(area_pin_wait0_c)
    );

    // Registered outputs; these lag the registers by one cycle, which the bus
    // state machine tolerates because settings change only between accesses.
    always @(posedge aclk) begin
        if (!aresetn) begin
            bus_8bit_mode <= 1'b0;
            port4_gpio <= 1'b0;
            addr_hi_out_en <= 3'h0;
            release_allowed <= 1'b0;
            area_is_8bit <= 1'b0;
            area_is_3state <= 1'b0;
            area_wait_ctl <= 1'b0;
            area_pin_wait0 <= 1'b0;
            wait_mode <= `EBAC_WMODE_PROG;
            wait_states <= 2'h3;
        end else begin
            bus_8bit_mode <= bus_8bit_mode_c; // [RULE2] [RULE3]
            port4_gpio <= port4_gpio_c; // [RULE2]
            addr_hi_out_en <= addr_hi_out_en_c; // [RULE13]
            release_allowed <= release_allowed_c; // [RULE15] [RULE17]
            area_is_8bit <= area_is_8bit_c; // [RULE1] [RULE5]
            area_is_3state <= area_is_3state_c; // [RULE6] [RULE7]
            area_wait_ctl <= area_wait_ctl_c; // [RULE11] [RULE18]
            area_pin_wait0 <= area_pin_wait0_c; // [RULE11]
            wait_mode <= wait_control_reg[`EBAC_WMS_HI:`EBAC_WMS_LO]; // [RULE9]
            wait_states <= wait_control_reg[`EBAC_WC_HI:`EBAC_WC_LO]; // [RULE10]
        end
    end
endmodule // ebac_top

// ===== ebac_top_asserts.sv
// Concurrent checks on the ports of the external bus area configuration bank.
// Assumes one clock domain and the synchronous active-low reset of the bank.
`timescale 1ns/10ps

module ebac_top_asserts #(
    parameter AREAS = 8
) (
    input wire aclk,
    input wire aresetn,
    input wire [2:0] op_mode,
    input wire onchip,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire bus_8bit_mode,
    input wire port4_gpio,
    input wire [2:0] addr_hi_out_en,
    input wire area_is_8bit,
    input wire area_is_3state,
    input wire area_wait_ctl,
    input wire area_pin_wait0,
    input wire [1:0] wait_mode,
    input wire [1:0] wait_states
);
    // ****************************************
    // Properties
    // ****************************************
    // One clock domain, so clock and reset are set once.
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    chk_port4_mode: assert property (port4_gpio == bus_8bit_mode)
        else $error("port 4 function disagrees with bus mode");
    chk_onchip_fixed: assert property (onchip |=> !area_is_8bit && !area_is_3state)
        else $error("on-chip target took area settings");
    chk_wait_ctl_area: assert property (area_wait_ctl |->
        area_is_3state && !area_pin_wait0)
        else $error("wait control on a non three-state area");
    chk_addr_hi_mode: assert property (addr_hi_out_en != 3'h0 |->
        $past(op_mode) inside {3'h3, 3'h4})
        else $error("upper address enabled outside modes three and four");
    chk_wait_reset: assert property ($rose(aresetn) |->
        wait_states == 2'h3 && wait_mode == 2'h0)
        else $error("wait fields wrong after reset");
    chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> s_axi_bvalid) else $error("write answer late");
    chk_rdata_lane: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read lanes not zero");

    // Main scenarios seen at least once.
    cov_slverr: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h2);
    cov_addr_hi: cover property (addr_hi_out_en == 3'h7);
    cov_pin_wait: cover property (area_pin_wait0);
endmodule // ebac_top_asserts

bind ebac_top ebac_top_asserts #(.AREAS(AREAS)) u_chk (.*);

// ===== ebac_far_model.sv
// Behavioural far side: an external bus master and a slow external memory.
// Assumes the bank's configuration outputs are wired straight to it.
`timescale 1ns/10ps

module ebac_far_model (
    input wire aclk,
    input wire want_bus,
    input wire release_allowed,
    input wire area_is_3state,
    output reg bus_request_in_n,
    output reg bus_granted,
    output reg wait_req_n
);
    // The master asks only while it wants the bus; the grant needs the release enable.
    // The memory asks for waits only on three-state areas, where the request counts.
    always @(posedge aclk) begin
        bus_request_in_n <= ~want_bus;
        bus_granted <= ~bus_request_in_n & release_allowed;
        wait_req_n <= ~area_is_3state;
    end
endmodule // ebac_far_model

// ===== test_external_bus_area_config.sv
// Self-checking bench for the configuration bank, driven through AXI4-Lite tasks.
// Assumes the register header and the far-side model are compiled first.
`timescale 1ns/10ps
`include "ebac_regs.vh"

module test_external_bus_area_config;
    // ****************************************
    // Signals
    // ****************************************
    logic aclk = 0, aresetn = 0, hw_standby = 0, sw_standby = 0, onchip = 0, want_bus = 0;
    logic [2:0] op_mode = 3'h3, area_sel = 3'h0, addr_hi_out_en;
    logic [`EBAC_ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, bus_8bit_mode, port4_gpio, release_allowed, area_is_8bit;
    logic area_is_3state, area_wait_ctl, area_pin_wait0, bus_request_in_n, bus_granted;
    logic wait_req_n;
    logic [1:0] s_axi_bresp, s_axi_rresp, wait_mode, wait_states;
    int error_cnt = 0, num_checks = 0;
    // Short names for the map; the unmapped address sits well below the bank.
    localparam logic [17:0] A_BW = `EBAC_ADDR_AREA_BUS_WIDTH, A_AS = `EBAC_ADDR_AREA_ACCESS_STATES;
    localparam logic [17:0] A_WC = `EBAC_ADDR_WAIT_CONTROL, A_WE = `EBAC_ADDR_WAIT_CONTROL_ENABLE;
    localparam logic [17:0] A_BR = `EBAC_ADDR_BUS_RELEASE_CONTROL, A_NONE = 18'h00000;
    localparam logic [1:0] OK = 2'h0, SLV = 2'h2;
    localparam logic [7:0] W = 8'h7F, S = 8'h05, E = 8'hFE;

    always #2 aclk = ~aclk;

    ebac_top #(.AREAS(8)) dut (.*);
    ebac_far_model far (.*);

    // ****************************************
    // Tasks
    // ****************************************
    // Compare and count; response codes ride above the data word.
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Address and data go out together; each is dropped at its own handshake edge.
    task automatic wr(input logic [17:0] a, input logic [7:0] d, input logic s0,
        input logic [1:0] er);
        logic aw_on;
        logic w_on;
        aw_on = 1;
        w_on = 1;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= {3'h7, s0};
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        while (aw_on || w_on) begin
            @(posedge aclk);
            if (aw_on && s_axi_awready) begin
                s_axi_awvalid <= 0;
                aw_on = 0;
            end
            if (w_on && s_axi_wready) begin
                s_axi_wvalid <= 0;
                w_on = 0;
            end
        end
        while (!s_axi_bvalid) @(posedge aclk);
        s_axi_bready <= 0;
        chk({s_axi_bresp, 32'h0}, {er, 32'h0});
        @(posedge aclk);
    endtask

    // One read; the last edge keeps the next request off this time step.
    task automatic rd(input logic [17:0] a, input logic [7:0] e, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        @(posedge aclk);
        while (!s_axi_arready) @(posedge aclk);
        s_axi_arvalid <= 0;
        while (!s_axi_rvalid) @(posedge aclk);
        s_axi_rready <= 0;
        chk({s_axi_rresp, s_axi_rdata}, {er, 24'h0, e});
        @(posedge aclk);
    endtask

    // Outputs and the far model each lag a cycle, so three edges pass.
    task automatic sel(input logic [2:0] a, input logic oc);
        area_sel <= a;
        onchip <= oc;
        repeat (3) @(posedge aclk);
    endtask

    task automatic results();
        if (error_cnt == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        rd(A_BW, 8'hFF, OK);
        rd(A_AS, 8'hFF, OK);
        rd(A_WC, 8'hF3, OK);
        rd(A_WE, 8'hFF, OK);
        rd(A_BR, 8'hFE, OK);
        chk({bus_8bit_mode, port4_gpio, release_allowed, addr_hi_out_en, wait_mode, wait_states},
            34'h303);
        wr(A_BW, W, 1, OK);
        wr(A_AS, S, 1, OK);
        wr(A_WE, E, 1, OK);
        rd(A_BW, W, OK);
        chk(bus_8bit_mode, 0);
        // Each area against its own bit of the three registers.
        for (int i = 0; i < 8; i++) begin
            sel(i[2:0], 0);
            chk({area_is_8bit, area_is_3state, area_wait_ctl, area_pin_wait0, wait_req_n},
                {W[i], S[i], S[i] & E[i], S[i] & ~E[i], ~S[i]});
            sel(i[2:0], 1);
            chk({area_is_8bit, area_is_3state}, 0);
        end
        // All four wait modes, each with a different count.
        for (int i = 0; i < 4; i++) begin
            wr(A_WC, {4'h0, i[1:0], ~i[1:0]}, 1, OK);
            rd(A_WC, {4'hF, i[1:0], ~i[1:0]}, OK);
            chk({wait_mode, wait_states}, {i[1:0], ~i[1:0]});
        end
        wr(A_BR, 8'h01, 1, OK);
        rd(A_BR, 8'h1F, OK);
        want_bus <= 1;
        repeat (3) @(posedge aclk);
        chk({addr_hi_out_en, release_allowed, bus_granted}, 5'h1F);
        wr(A_BR, 8'hE0, 1, OK);
        rd(A_BR, 8'hFE, OK);
        chk({addr_hi_out_en, release_allowed, bus_granted}, 5'h00);
        // A write with lane 0 off changes nothing; unmapped places are refused.
        wr(A_BR, 8'h01, 0, OK);
        rd(A_BR, 8'hFE, OK);
        wr(A_NONE, 8'h00, 1, SLV);
        rd(A_NONE, 8'h00, SLV);
        sw_standby <= 1;
        rd(A_BW, W, OK);
        rd(A_AS, S, OK);
        rd(A_WE, E, OK);
        rd(`EBAC_ADDR_BUS_STATUS, 8'h31, OK);
        sw_standby <= 0;
        hw_standby <= 1;
        repeat (2) @(posedge aclk);
        hw_standby <= 0;
        @(posedge aclk);
        rd(A_BW, 8'hFF, OK);
        rd(A_AS, 8'hFF, OK);
        rd(A_WC, 8'hF3, OK);
        // Second reset in a mode without upper address lines and with a wide bus.
        aresetn <= 0;
        op_mode <= 3'h2;
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        rd(A_BW, 8'h00, OK);
        chk(bus_8bit_mode, 0);
        wr(A_BR, 8'h01, 1, OK);
        rd(A_BR, 8'hFF, OK);
        chk(addr_hi_out_en, 0);
        results();
    end

    // A hang counts as a mismatch.
    initial begin
        repeat (5000) @(posedge aclk);
        error_cnt++;
        results();
    end
endmodule // test_external_bus_area_config
